// ---- core/led_scan_defines.vh ----
// register map, field positions, reset values and timing counts for the led scan driver
`ifndef LED_SCAN_DEFINES_VH
`define LED_SCAN_DEFINES_VH

// register indices; byte address is four times the index
`define IDX_DISPLAY_CONTROL 8'hB1
`define IDX_DISPLAY_CONTROL_TWO 8'hB2
`define IDX_SEG_PIN_FUNCTION 8'hB3
`define IDX_SCAN_STATUS 8'hB4
`define IDX_DISP_MEM_BASE 8'hC0

// display_control fields
`define BIT_DISPLAY_ON 7
`define RST_DISPLAY_CONTROL 8'h44
`define MASK_DISPLAY_CONTROL 8'hC7

// display_control_two fields
`define BIT_CLK_SRC_SEL 7
`define BIT_PRESCALE_HI 6
`define BIT_PRESCALE_LO 5
`define BIT_LED_MODE 4
`define BIT_COM_POLARITY 3
`define BIT_DEAD_TIME_EN 2
`define RST_DISPLAY_CONTROL_TWO 8'h00
`define MASK_DISPLAY_CONTROL_TWO 8'hFC

// segment_pin_function reset
`define RST_SEG_PIN_FUNCTION 8'h00

// matrix shape
`define NUM_SEG 18
`define NUM_COM 4

// prescaler divide values, less one
`define DIV_256_M1 8'hFF
`define DIV_128_M1 8'h7F
`define DIV_64_M1 8'h3F
`define DIV_32_M1 8'h1F

// dead time length in display clock ticks from step start
`define DEAD_TICKS 8'h08

`endif

// ---- core/led_matrix_scan_driver.v ----
// led matrix scan driver with avalon-mm register slave and shared display memory
//
// Operation
// - led mode bit swaps lcd for led drive
// - drive 18 segments, 4 commons, 72 pixels
// - shared clock source and shared display memory
// - polarity bit: 0 active low, 1 high
// - dead time parks common inactive between steps
// - display on bit gates all output
// - source bit: 0 rc, 1 crystal
// - prescale codes divide by 256,128,64,32
// - pin bits hand pins to display
//
// Chosen here: the Avalon-MM register port.
`include "led_scan_defines.vh"

module led_matrix_scan_driver (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // avalon-mm slave
  input wire [9:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  // slow oscillators, synchronous levels
  input wire slow_rc_osc,
  input wire slow_crystal_osc,
  // matrix pins
  output reg [17:0] seg_out,
  output reg [17:0] seg_disp_en,
  output reg [3:0] com_out,
  output reg lcd_mode_active
);

  // one-hot scan states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_DEAD = 3'b010;
  localparam [2:0] ST_DRIVE = 3'b100;

  // software registers
  reg [7:0] disp_ctrl_q; // display_control
  reg [7:0] disp_ctrl2_q; // display_control_two
  reg [7:0] pin_func_q; // segment_pin_function
  reg [17:0] disp_mem_q [0:3]; // display_memory, one row per common

  // bus handshake
  reg ack_q; // high in the cycle waitrequest is low
  wire [7:0] reg_idx; // word index of the access
  wire bus_req; // request pending
  wire wr_take; // write commits this edge
  reg [31:0] rd_d; // read mux

  // oscillator edge and prescaler
  reg rc_prev_q;
  reg xt_prev_q;
  wire src_level; // selected oscillator
  wire src_prev;
  wire disp_tick; // one-cycle enable per display clock edge
  reg [7:0] pre_cnt_q; // prescaler counter
  reg [7:0] div_m1; // divide limit less one
  wire step_tick; // end of scan step

  // scan state
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [1:0] step_q; // active common index
  reg [7:0] dead_cnt_q; // ticks spent in dead time

  // decoded controls
  wire display_on;
  wire led_mode_select;
  wire common_polarity_sel;
  wire common_dead_time_en;
  wire display_clk_src_sel;
  wire [1:0] display_clk_prescale;
  wire led_run; // led scan may run
  wire [17:0] pin_map; // per segment pin ownership

  assign display_on = disp_ctrl_q[`BIT_DISPLAY_ON];
  assign led_mode_select = disp_ctrl2_q[`BIT_LED_MODE];
  assign common_polarity_sel = disp_ctrl2_q[`BIT_COM_POLARITY];
  assign common_dead_time_en = disp_ctrl2_q[`BIT_DEAD_TIME_EN];
  assign display_clk_src_sel = disp_ctrl2_q[`BIT_CLK_SRC_SEL];
  assign display_clk_prescale = disp_ctrl2_q[`BIT_PRESCALE_HI:`BIT_PRESCALE_LO];

  // led scan gated by display on and led mode select
  assign led_run = display_on & led_mode_select;

  // word addressing: bottom two byte bits ignored
  assign reg_idx = address[9:2];
  assign bus_req = read | write;
  assign wr_take = write & ack_q;

  // read mux; unmapped words read zero
  always @* begin
    rd_d = 32'h0000_0000;
    case (reg_idx)
      `IDX_DISPLAY_CONTROL: begin
        rd_d[7:0] = disp_ctrl_q;
      end
      `IDX_DISPLAY_CONTROL_TWO: begin
        rd_d[7:0] = disp_ctrl2_q;
      end
      `IDX_SEG_PIN_FUNCTION: begin
        rd_d[7:0] = pin_func_q;
      end
      `IDX_SCAN_STATUS: begin
        // live scan state for software
        rd_d[1:0] = step_q;
        rd_d[2] = state_q[1];
        rd_d[3] = state_q[2];
        rd_d[4] = led_run;
      end
      `IDX_DISP_MEM_BASE: begin
        rd_d[17:0] = disp_mem_q[0];
      end
      `IDX_DISP_MEM_BASE + 8'h01: begin
        rd_d[17:0] = disp_mem_q[1];
      end
      `IDX_DISP_MEM_BASE + 8'h02: begin
        rd_d[17:0] = disp_mem_q[2];
      end
      `IDX_DISP_MEM_BASE + 8'h03: begin
        rd_d[17:0] = disp_mem_q[3];
      end
      default: begin
        rd_d = 32'h0000_0000;
      end
    endcase
  end

  // one wait cycle per access; readdata captured with the ack
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
    end else begin
      if (bus_req && !ack_q) begin
        // accept: drop waitrequest for exactly one cycle
        ack_q <= 1'b1;
        waitrequest <= 1'b0;
        readdata <= rd_d;
      end else begin
        // master releases after the ack edge
        ack_q <= 1'b0;
        waitrequest <= 1'b1;
      end
    end
  end

  // control register writes, low byte only
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      disp_ctrl_q <= `RST_DISPLAY_CONTROL;
      disp_ctrl2_q <= `RST_DISPLAY_CONTROL_TWO;
      pin_func_q <= `RST_SEG_PIN_FUNCTION;
    end else if (wr_take) begin
      case (reg_idx)
        `IDX_DISPLAY_CONTROL: begin
          // reserved bits stay zero
          disp_ctrl_q <= writedata[7:0] & `MASK_DISPLAY_CONTROL;
        end
        `IDX_DISPLAY_CONTROL_TWO: begin
          disp_ctrl2_q <= writedata[7:0] & `MASK_DISPLAY_CONTROL_TWO;
        end
        `IDX_SEG_PIN_FUNCTION: begin
          pin_func_q <= writedata[7:0];
        end
        default: begin
          // status and unmapped: ignored
          pin_func_q <= pin_func_q;
        end
      endcase
    end
  end

  // shared display memory rows, written by software
  genvar r;
  generate
    for (r = 0; r < `NUM_COM; r = r + 1) begin : g_mem
      // word index of this row, kept wide and sliced on purpose
      localparam [31:0] ROW_IDX = `IDX_DISP_MEM_BASE + r;
      always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          disp_mem_q[r] <= 18'h0_0000;
        end else if (wr_take && reg_idx == ROW_IDX[7:0]) begin
          disp_mem_q[r] <= writedata[17:0];
        end
      end
    end
  endgenerate

  // remember oscillator levels to find rising edges
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rc_prev_q <= 1'b0;
      xt_prev_q <= 1'b0;
    end else begin
      rc_prev_q <= slow_rc_osc;
      xt_prev_q <= slow_crystal_osc;
    end
  end

  // source select; both oscillators tracked so switching makes no false tick
  assign src_level = display_clk_src_sel ? slow_crystal_osc : slow_rc_osc;
  assign src_prev = display_clk_src_sel ? xt_prev_q : rc_prev_q;
  assign disp_tick = src_level & ~src_prev;

  // prescale limit
  always @* begin
    case (display_clk_prescale)
      2'b00: div_m1 = `DIV_256_M1;
      2'b01: div_m1 = `DIV_128_M1;
      2'b10: div_m1 = `DIV_64_M1;
      default: div_m1 = `DIV_32_M1;
    endcase
  end

  // prescaler counts display clock ticks; a lowered limit wraps at once
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pre_cnt_q <= 8'h00;
    end else if (!led_run) begin
      pre_cnt_q <= 8'h00;
    end else if (disp_tick) begin
      if (pre_cnt_q >= div_m1) begin
        pre_cnt_q <= 8'h00;
      end else begin
        pre_cnt_q <= pre_cnt_q + 8'h01;
      end
    end
  end

  assign step_tick = disp_tick & (pre_cnt_q >= div_m1);

  // scan next state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (led_run) begin
          state_d = common_dead_time_en ? ST_DEAD : ST_DRIVE;
        end
      end
      ST_DEAD: begin
        // dead time counted from the start of each step
        if (!led_run) begin
          state_d = ST_IDLE;
        end else if (step_tick) begin
          state_d = common_dead_time_en ? ST_DEAD : ST_DRIVE;
        end else if (dead_cnt_q >= `DEAD_TICKS || !common_dead_time_en) begin
          state_d = ST_DRIVE;
        end
      end
      ST_DRIVE: begin
        if (!led_run) begin
          state_d = ST_IDLE;
        end else if (step_tick && common_dead_time_en) begin
          state_d = ST_DEAD;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // scan state, step and dead counter
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      step_q <= 2'b00;
      dead_cnt_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (!led_run) begin
        step_q <= 2'b00;
      end else if (step_tick) begin
        step_q <= step_q + 2'b01;
      end
      if (step_tick || state_q != ST_DEAD) begin
        dead_cnt_q <= 8'h00;
      end else if (disp_tick) begin
        dead_cnt_q <= dead_cnt_q + 8'h01;
      end
    end
  end

  // segment pin ownership: groups follow the pin function bits
  generate
    for (r = 0; r < `NUM_SEG; r = r + 1) begin : g_pin
      if (r >= 12) begin : g_single
        assign pin_map[r] = pin_func_q[r - 10];
      end else if (r >= 8) begin : g_grp1
        assign pin_map[r] = pin_func_q[1];
      end else if (r >= 4) begin : g_grp0
        assign pin_map[r] = pin_func_q[0];
      end else begin : g_fixed
        // lowest four segments have no shared i/o
        assign pin_map[r] = 1'b1;
      end
    end
  endgenerate

  // registered pin drive
  genvar c;
  generate
    for (c = 0; c < `NUM_COM; c = c + 1) begin : g_com
      // step index at which this common is active
      localparam [31:0] COM_IDX = c;
      always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          com_out[c] <= 1'b1;
        end else if (led_run && state_q == ST_DRIVE && step_q == COM_IDX[1:0]) begin
          com_out[c] <= common_polarity_sel;
        end else begin
          // inactive level, also during dead time
          com_out[c] <= ~common_polarity_sel;
        end
      end
    end
  endgenerate

  // segments show the active row, only on owned pins
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      seg_out <= 18'h0_0000;
      seg_disp_en <= 18'h0_0000;
      lcd_mode_active <= 1'b0;
    end else begin
      seg_disp_en <= display_on ? pin_map : 18'h0_0000;
      lcd_mode_active <= display_on & ~led_mode_select;
      if (led_run && state_q == ST_DRIVE) begin
        seg_out <= disp_mem_q[step_q] & pin_map;
      end else begin
        seg_out <= 18'h0_0000;
      end
    end
  end

endmodule

// ---- dv/led_scan_assertions.sv ----
// port-level checks for the led matrix scan driver
module led_scan_assertions (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // bus handshake
  input wire read,
  input wire write,
  input wire waitrequest,
  // matrix pins
  input wire [17:0] seg_out,
  input wire [17:0] seg_disp_en,
  input wire [3:0] com_out,
  input wire lcd_mode_active
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // request seen while slave idle
  sequence s_taken;
    (read || write) && waitrequest;
  endsequence
  // one-cycle acknowledge
  sequence s_ack;
    !waitrequest ##1 waitrequest;
  endsequence
  a_ack_once: assert property (s_taken |=> s_ack) else $error("ack missing or long");
  a_no_stray_ack: assert property (!waitrequest |-> $past(read || write))
    else $error("ack without request");
  a_single_com: assert property ($countones(com_out) != 2)
    else $error("two commons lit");
  // lit segments only beside exactly one active common, either polarity
  a_seg_one_com: assert property (|seg_out |-> $countones(com_out) inside {1, 3})
    else $error("segments lit without one common");
  a_com_holds: assert property ($changed(com_out) |=> $stable(com_out) [*4])
    else $error("common glitch");
  a_lcd_dark: assert property (lcd_mode_active [*3] |-> seg_out == 18'h0)
    else $error("segments lit in lcd mode");
  a_off_dark: assert property (!seg_disp_en[0] [*3] |-> seg_out == 18'h0 && !lcd_mode_active)
    else $error("output while display off");
  a_group_own: assert property (seg_disp_en[11:8] inside {4'h0, 4'hF})
    else $error("pin group split");
  a_base_owned: assert property (|seg_disp_en[17:4] |-> seg_disp_en[3:0] == 4'hF)
    else $error("low segments not owned");
  a_lcd_owned: assert property (lcd_mode_active && $past(lcd_mode_active) |-> seg_disp_en[0])
    else $error("lcd mode without display pins");
endmodule

bind led_matrix_scan_driver led_scan_assertions led_scan_assertions_i (
  .clock(clock),
  .sys_rst(sys_rst),
  .read(read),
  .write(write),
  .waitrequest(waitrequest),
  .seg_out(seg_out),
  .seg_disp_en(seg_disp_en),
  .com_out(com_out),
  .lcd_mode_active(lcd_mode_active)
);

// ---- dv/led_matrix_model.sv ----
// led matrix module: decodes the lit common and latches its row
module led_matrix_model (
  input wire clock,
  input wire pol,
  input wire [3:0] com_out,
  input wire [17:0] seg_out,
  output logic [2:0] act,
  output logic [17:0] lit
);
  logic [3:0] on;
  // wiring of the module decides which level lights a common
  assign on = pol ? com_out : ~com_out;
  // index of the single lit common, 4 when none or several
  always_comb begin
    case (on)
      4'h1: act = 3'h0;
      4'h2: act = 3'h1;
      4'h4: act = 3'h2;
      4'h8: act = 3'h3;
      default: act = 3'h4;
    endcase
  end
  // row visible while its common is lit
  always @(posedge clock) if (act != 3'h4) lit <= seg_out;
endmodule

// ---- dv/led_matrix_scan_driver_tb.sv ----
// self-checking bench for the led matrix scan driver
module led_matrix_scan_driver_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, sys_rst = 1, read = 0, write = 0, pol = 0;
  logic slow_rc_osc = 0, slow_crystal_osc = 0;
  logic [9:0] address = 0;
  logic [31:0] writedata = 0, readdata, rd;
  logic waitrequest, lcd_mode_active;
  logic [17:0] seg_out, seg_disp_en, lit;
  logic [17:0] row [4];
  logic [7:0] p;
  logic [3:0] com_out;
  logic [2:0] act;
  int n_fail = 0, samples_checked = 0, cyc = 0, hold, gap, k0;
  led_matrix_scan_driver led_matrix_scan_driver_i (
    .clock(clock),
    .sys_rst(sys_rst),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .slow_rc_osc(slow_rc_osc),
    .slow_crystal_osc(slow_crystal_osc),
    .seg_out(seg_out),
    .seg_disp_en(seg_disp_en),
    .com_out(com_out),
    .lcd_mode_active(lcd_mode_active)
  );
  led_matrix_model led_matrix_model_i (
    .clock(clock),
    .pol(pol),
    .com_out(com_out),
    .seg_out(seg_out),
    .act(act),
    .lit(lit)
  );
  always #25 clock = ~clock;
  // rc ticks every 2 clocks, crystal every 4, so the step length shows the source
  always @(posedge clock) begin
    cyc <= cyc + 1;
    slow_rc_osc <= ~slow_rc_osc;
    if (cyc[0]) slow_crystal_osc <= ~slow_crystal_osc;
    if (cyc == 40000) begin
      n_fail++;
      end_sim();
    end
  end
  task end_sim();
    $display("checks %0d errors %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  task bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clock);
    address <= {idx, 2'h0};
    write <= wr;
    read <= !wr;
    writedata <= wd;
    do @(posedge clock); while (waitrequest !== 1'h0);
    rd = readdata;
    read <= 0;
    write <= 0;
  endtask
  task rchk(input logic [7:0] idx, input logic [31:0] exp, input string nm);
    bus(0, idx, 0);
    check(nm, rd, exp);
  endtask
  // pins owned by display for a pin-function byte
  function logic [17:0] seg_own(input logic [7:0] q);
    return {q[7:2], {4{q[1]}}, {4{q[0]}}, 4'hF};
  endfunction
  // reconfigure with display off, then time two scan steps
  task scan(input logic [7:0] cfg);
    int exp, per;
    // display clock period in system clocks: rc 2, crystal 4
    per = cfg[7] ? 4 : 2;
    exp = (256 >> cfg[6:5]) * per;
    bus(1, 8'hB1, 32'h44);
    repeat (8) @(posedge clock);
    bus(1, 8'hB2, {24'h0, cfg});
    pol <= cfg[3];
    repeat (8) @(posedge clock);
    check("idle_com", com_out, cfg[3] ? 4'h0 : 4'hF);
    bus(1, 8'hB1, 32'hC4);
    // skip the first step, whose start depends on tick phase
    while (act !== 3'h1) @(negedge clock);
    repeat (2) begin
      k0 = act;
      hold = 0;
      gap = 0;
      while (act == k0) begin
        @(negedge clock);
        hold++;
      end
      check("row", lit, row[k0]);
      while (act == 3'h4) begin
        @(negedge clock);
        gap++;
      end
      check("next_com", act, (k0 + 1) % 4);
      check("step_len", hold + gap, exp);
      // dead time is eight display ticks plus up to two clocks of pipeline
      check("dead", gap >= 8 * per && gap <= 8 * per + 2, cfg[2]);
    end
    // let the last common settle before the display is switched off
    repeat (8) @(posedge clock);
  endtask
  initial begin
    void'($urandom(50373));
    repeat (4) @(posedge clock);
    sys_rst <= 0;
    rchk(8'hB1, 32'h44, "ctrl_rst");
    rchk(8'hB2, 32'h00, "ctrl2_rst");
    rchk(8'hB3, 32'h00, "pin_rst");
    rchk(8'hA0, 32'h00, "unmapped");
    rchk(8'hB4, 32'h00, "status_idle");
    check("off_own", seg_disp_en, 0);
    for (int i = 0; i < 4; i++) begin
      row[i] = 18'($urandom);
      bus(1, 8'(8'hC0 + i), {14'h0, row[i]});
      rchk(8'(8'hC0 + i), {14'h0, row[i]}, "row_rb");
    end
    p = 8'($urandom);
    bus(1, 8'hB3, {24'h0, p});
    bus(1, 8'hB2, {24'h0, p & 8'hEF});
    bus(1, 8'hB1, 32'hFF);
    rchk(8'hB1, 32'hC7, "ctrl_rb");
    rchk(8'hB2, {24'h0, p & 8'hEC}, "ctrl2_rb");
    rchk(8'hB3, {24'h0, p}, "pin_rb");
    check("pin_own", seg_disp_en, seg_own(p));
    check("lcd_mode", lcd_mode_active, 1);
    bus(1, 8'hB3, 32'hFF);
    for (int c = 0; c < 8; c++) begin
      scan({c[0], c[2:1], 1'h1, 1'($urandom), c[0] ^ c[1], 2'h3});
    end
    bus(1, 8'hB1, 32'h44);
    repeat (8) @(posedge clock);
    check("off_seg", seg_out, 0);
    end_sim();
  end
endmodule
